// >>> src/bal_consts.svh
/*
 * Offsets, field positions, reset values and widths for the byte ALU.
 * Assumes it is included by its bare name, after the package, by the
 * files of the byte ALU only.
 */
// Functional notes
// RQ1 - File minus work; carry if work <= file, half borrow on bits 3:0.
// RQ2 - Destination bit 0 writes the work register, 1 the addressed file.
// RQ3 - XOR literal puts work XOR the 8-bit immediate in work, zero only.
// RQ4 - Nibble swap exchanges bits 7:4 and 3:0 of file and touches no flag.
// RQ5 - XOR with file goes to the chosen destination and changes only zero.
// RQ6 - An updated zero flag is set for an all-zero result, else cleared.
`ifndef BAL_CONSTS_SVH
`define BAL_CONSTS_SVH

// Register byte offsets on the bus
`define BAL_OFS_WORK      8'h00
`define BAL_OFS_STATUS    8'h04
`define BAL_OFS_RESULT    8'h08

// Status register field positions
`define BAL_BIT_CARRY     0
`define BAL_BIT_HALF      1
`define BAL_BIT_ZERO      2

// Reset values
`define BAL_RST_WORK      8'h00
`define BAL_RST_FLAGS     3'h0
`define BAL_RST_RESULT    8'h00

// Widths
`define BAL_FILE_AW       7
`define BAL_BUS_AW        8

`endif

// >>> src/bal_pkg.sv
/*
 * Types shared by the byte ALU modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package bal_pkg;

    // Operation select from the instruction decoder
    typedef enum logic [1:0] {
        BAL_SUB_WORK_FROM_FILE_OP,
        BAL_XOR_LITERAL_OP,
        BAL_NIBBLE_SWAP_OP,
        BAL_XOR_FILE_OP
    } bal_op_t;

    // Status flags; bit 0 carry, bit 1 half borrow, bit 2 zero
    typedef struct packed {
        logic zero;
        logic half_borrow_flag;
        logic carry;
    } bal_flags_t;

endpackage
`default_nettype wire

// >>> src/bal_reg_if.sv
/*
 * Carrier between the bus slave and the ALU core registers.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface bal_reg_if;
    logic               wr_work;
    logic               wr_status;
    logic [7:0]         wdata;
    logic [7:0]         work;
    bal_pkg::bal_flags_t flags;
    logic [7:0]         result;

    modport bus  (output wr_work, output wr_status, output wdata,
                  input work, input flags, input result);
    modport core (input wr_work, input wr_status, input wdata,
                  output work, output flags, output result);
endinterface
`default_nettype wire

// >>> src/bal_exec.sv
/*
 * Combinational operation unit: result and updated flags for one op.
 * Assumes operands are stable during the cycle the op is presented.
 */
`timescale 1ns/10ps
`default_nettype none
module bal_exec
(
    input  wire bal_pkg::bal_op_t    op_i,
    input  wire logic [7:0]          work_i,
    input  wire logic [7:0]          file_i,
    input  wire logic [7:0]          lit_i,
    input  wire bal_pkg::bal_flags_t flags_i,
    output logic [7:0]               result_o,
    output bal_pkg::bal_flags_t      flags_o
);

    // Subtract a minus b as a plus not b plus one; top bit is no-borrow
    function automatic logic [8:0] sub_nb(input logic [7:0] a,
                                          input logic [7:0] b);
        sub_nb = {1'b0, a} + {1'b0, ~b} + 9'h001;
    endfunction

    logic [8:0] full_diff;
    logic [8:0] low_diff;

    assign full_diff = sub_nb(file_i, work_i);
    assign low_diff  = sub_nb({4'h0, file_i[3:0]}, {4'h0, work_i[3:0]});

    // Select result and flag updates per operation
    always_comb
    begin
        result_o = 8'h00;
        flags_o  = flags_i;
        unique case (op_i)
            bal_pkg::BAL_SUB_WORK_FROM_FILE_OP:
            begin
                result_o               = full_diff[7:0];          // [RQ1]
                flags_o.carry          = full_diff[8];            // [RQ1]
                flags_o.half_borrow_flag = ~low_diff[4];          // [RQ1]
                flags_o.zero           = (full_diff[7:0] == 8'h00); // [RQ6]
            end
            bal_pkg::BAL_XOR_LITERAL_OP:
            begin
                result_o     = work_i ^ lit_i;                    // [RQ3]
                flags_o.zero = ((work_i ^ lit_i) == 8'h00);  // [RQ3] [RQ6]
            end
            bal_pkg::BAL_NIBBLE_SWAP_OP:
            begin
                result_o = {file_i[3:0], file_i[7:4]};            // [RQ4]
            end
            bal_pkg::BAL_XOR_FILE_OP:
            begin
                result_o     = work_i ^ file_i;                   // [RQ5]
                flags_o.zero = ((work_i ^ file_i) == 8'h00); // [RQ5] [RQ6]
            end
        endcase
    end

endmodule
`default_nettype wire

// >>> src/bal_wb_slave.sv
/*
 * Classic Wishbone slave for the byte ALU registers.
 * Assumes a classic single-cycle master holding its request until ack.
 */
`timescale 1ns/10ps
`default_nettype none
`include "bal_consts.svh"
module bal_wb_slave
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [`BAL_BUS_AW-1:0] wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic [31:0]                 wb_dat_o,
    output logic                        wb_ack_o,
    bal_reg_if.bus                      regs
);

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } bal_wb_state_t;

    bal_wb_state_t q;
    bal_wb_state_t next_q;
    logic          req;
    logic          low_lane;

    assign req      = wb_cyc_i & wb_stb_i;
    assign low_lane = wb_sel_i[0];

    // Writes land on the edge where the master sees ack
    assign regs.wdata     = wb_dat_i[7:0];
    assign regs.wr_work   = req & q.ack & wb_we_i & low_lane
                            & (wb_adr_i == `BAL_OFS_WORK);
    assign regs.wr_status = req & q.ack & wb_we_i & low_lane
                            & (wb_adr_i == `BAL_OFS_STATUS);
    assign wb_ack_o       = q.ack;
    assign wb_dat_o       = q.dat;

    // Ack one cycle after the request, read data captured alongside
    always_comb
    begin
        next_q     = q;
        next_q.ack = req & ~q.ack;
        next_q.dat = 32'h0000_0000;
        if (req & ~q.ack & ~wb_we_i)
        begin
            if (wb_adr_i == `BAL_OFS_WORK)
                next_q.dat = {24'h00_0000, regs.work};
            else if (wb_adr_i == `BAL_OFS_STATUS)
                next_q.dat = {29'h0000_0000, regs.flags};
            else if (wb_adr_i == `BAL_OFS_RESULT)
                next_q.dat = {24'h00_0000, regs.result};
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            q <= '0;
        else
            q <= next_q;
    end

endmodule
`default_nettype wire

// >>> src/bal_top.sv
/*
 * Byte ALU slice: subtract from file, XOR literal, nibble swap and
 * XOR with file, with work register and flags reachable over Wishbone.
 * Assumes the decoder presents op and file operand in the same cycle,
 * and that the register file accepts a one-cycle write strobe.
 */
`timescale 1ns/10ps
`default_nettype none
`include "bal_consts.svh"
module bal_top
(
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [`BAL_BUS_AW-1:0]  wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic [31:0]                  wb_dat_o,
    output logic                         wb_ack_o,
    input  wire logic                    op_valid_i,
    input  wire logic [1:0]              op_code_i,
    input  wire logic                    dest_i,
    input  wire logic [`BAL_FILE_AW-1:0] file_addr_i,
    input  wire logic [7:0]              file_rdata_i,
    input  wire logic [7:0]              literal_i,
    output logic                         file_we_o,
    output logic [`BAL_FILE_AW-1:0]      file_waddr_o,
    output logic [7:0]                   file_wdata_o,
    output logic                         done_o,
    output logic [7:0]                   work_o,
    output logic [2:0]                   flags_o
);

    typedef struct packed {
        logic [7:0]                work;
        bal_pkg::bal_flags_t       flags;
        logic [7:0]                result;
        logic                      file_we;
        logic [`BAL_FILE_AW-1:0]   file_waddr;
        logic [7:0]                file_wdata;
        logic                      done;
    } bal_top_state_t;

    bal_top_state_t      q;
    bal_top_state_t      next_q;
    bal_reg_if           regs ();
    bal_pkg::bal_op_t    op;
    logic [7:0]          ex_result;
    bal_pkg::bal_flags_t ex_flags;
    logic                to_file;

    assign op = bal_pkg::bal_op_t'(op_code_i);

    // Literal XOR always returns to work; others follow the select bit
    assign to_file = dest_i & (op != bal_pkg::BAL_XOR_LITERAL_OP); // [RQ2] [RQ3]

    bal_exec u_exec
    (
        .op_i     (op),
        .work_i   (q.work),
        .file_i   (file_rdata_i),
        .lit_i    (literal_i),
        .flags_i  (q.flags),
        .result_o (ex_result),
        .flags_o  (ex_flags)
    );

    bal_wb_slave u_wb
    (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .regs     (regs.bus)
    );

    // Register view for the bus slave
    assign regs.work   = q.work;
    assign regs.flags  = q.flags;
    assign regs.result = q.result;

    // Outputs straight from state
    assign file_we_o    = q.file_we;
    assign file_waddr_o = q.file_waddr;
    assign file_wdata_o = q.file_wdata;
    assign done_o       = q.done;
    assign work_o       = q.work;
    assign flags_o      = q.flags;

    // Next state: an operation wins over a bus write in the same cycle
    always_comb
    begin
        next_q         = q;
        next_q.file_we = 1'b0;
        next_q.done    = 1'b0;
        if (op_valid_i)
        begin
            next_q.result = ex_result;
            next_q.flags  = ex_flags;          // [RQ1] [RQ4] [RQ6]
            next_q.done   = 1'b1;
            if (to_file)
            begin
                next_q.file_we    = 1'b1;      // [RQ2]
                next_q.file_waddr = file_addr_i;
                next_q.file_wdata = ex_result;
            end
            else
            begin
                next_q.work = ex_result;       // [RQ2]
            end
        end
        else
        begin
            if (regs.wr_work)
                next_q.work = regs.wdata;
            if (regs.wr_status)
                next_q.flags = bal_pkg::bal_flags_t'(regs.wdata[2:0]);
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q        <= '0;
            q.work   <= `BAL_RST_WORK;
            q.flags  <= `BAL_RST_FLAGS;
            q.result <= `BAL_RST_RESULT;
        end
        else
        begin
            q <= next_q;
        end
    end

endmodule
`default_nettype wire

// >>> sim/bal_top_assertions.sv
/*
 * Checker for the byte ALU top: bus handshake, result routing, flags.
 * Assumes it is bound to bal_top and sees only its ports.
 */
`timescale 1ns/10ps
`default_nettype none
module bal_top_chk
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic       op_valid_i,
    input wire logic [1:0] op_code_i,
    input wire logic       dest_i,
    input wire logic [6:0] file_addr_i,
    input wire logic [7:0] file_rdata_i,
    input wire logic [7:0] literal_i,
    input wire logic       file_we_o,
    input wire logic [6:0] file_waddr_o,
    input wire logic [7:0] file_wdata_o,
    input wire logic       done_o,
    input wire logic [7:0] work_o,
    input wire logic [2:0] flags_o
);
    logic [7:0] swp;
    logic       fop;

    // Swapped operand and file-bound op, for the checks below
    assign swp = {file_rdata_i[3:0], file_rdata_i[7:4]};
    assign fop = op_valid_i && dest_i && op_code_i != 2'h1;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    op_done_a: assert property (op_valid_i |=> done_o)
        else $error("done missing after op");
    bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    to_file_a: assert property (fop |=> file_we_o &&
        file_waddr_o == $past(file_addr_i)) else $error("file write bad");
    to_work_a: assert property (op_valid_i && !fop |=> !file_we_o)
        else $error("stray file write");
    swap_flags_a: assert property (op_valid_i && op_code_i == 2'h2
        |=> $stable(flags_o)) else $error("swap changed flags");
    swap_data_a: assert property (fop && op_code_i == 2'h2
        |=> file_wdata_o == $past(swp)) else $error("swap data bad");
    lit_xor_a: assert property (op_valid_i && op_code_i == 2'h1
        |=> work_o == ($past(work_o) ^ $past(literal_i)))
        else $error("xor literal bad");
    sub_carry_a: assert property (op_valid_i && op_code_i == 2'h0
        |=> flags_o[0] == ($past(work_o) <= $past(file_rdata_i)))
        else $error("sub carry bad");
    xor_file_a: assert property (fop && op_code_i == 2'h3
        |=> file_wdata_o == ($past(file_rdata_i) ^ $past(work_o)))
        else $error("xor file data bad");
    zero_flag_a: assert property (op_valid_i && op_code_i == 2'h3
        && !dest_i |=> flags_o[2] == (work_o == 8'h00))
        else $error("zero flag bad");

    cover property (fop && op_code_i == 2'h0);
    cover property (op_valid_i && op_code_i == 2'h1);
    cover property (fop && op_code_i == 2'h2);
    cover property (fop && op_code_i == 2'h3);
endmodule

bind bal_top bal_top_chk i_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .op_valid_i(op_valid_i), .op_code_i(op_code_i), .dest_i(dest_i),
    .file_addr_i(file_addr_i), .file_rdata_i(file_rdata_i),
    .literal_i(literal_i), .file_we_o(file_we_o),
    .file_waddr_o(file_waddr_o), .file_wdata_o(file_wdata_o),
    .done_o(done_o), .work_o(work_o), .flags_o(flags_o));
`default_nettype wire

// >>> sim/bal_file_model.sv
/*
 * Register file model facing the byte ALU.
 * Assumes the operand address is presented with the op.
 */
`timescale 1ns/10ps
`default_nettype none
module bal_file_model
(
    input  wire logic       clk_i,
    input  wire logic [6:0] raddr_i,
    output logic [7:0]      rdata_o,
    input  wire logic       we_i,
    input  wire logic [6:0] waddr_i,
    input  wire logic [7:0] wdata_i
);
    logic [7:0] mem [128];

    // Operand read is combinational
    assign rdata_o = mem[raddr_i];

    // Write-back on the strobe edge
    always @(posedge clk_i)
        if (we_i)
            mem[waddr_i] <= wdata_i;
endmodule
`default_nettype wire

// >>> sim/test_byte_alu_sub_xor_swap.sv
/*
 * Bench for the byte ALU: bus access, four ops, both destinations.
 * Assumes bal_top, its checker and the file model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        n_tests++; \
        if ((g) !== (e)) \
        begin \
            error_cnt++; \
            $display("[FAIL] %s exp %0h got %0h", nm, e, g); \
        end \
    end
module test_byte_alu_sub_xor_swap;
    logic        clk_i;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic        opv = 1'b0;
    logic        dest = 1'b0;
    logic        ack, fwe, done;
    logic [1:0]  opc = 2'h0;
    logic [3:0]  sel = 4'hF;
    logic [6:0]  fa = 7'h00;
    logic [6:0]  fwa;
    logic [7:0]  adr = 8'h00;
    logic [7:0]  lit = 8'h00;
    logic [7:0]  frd, fwd, work, q;
    logic [2:0]  flags;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    int          error_cnt = 0;
    int          n_tests = 0;

    bal_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .op_valid_i(opv), .op_code_i(opc), .dest_i(dest),
        .file_addr_i(fa), .file_rdata_i(frd), .literal_i(lit),
        .file_we_o(fwe), .file_waddr_o(fwa), .file_wdata_o(fwd),
        .done_o(done), .work_o(work), .flags_o(flags));
    bal_file_model i_file (.clk_i(clk_i), .raddr_i(fa), .rdata_o(frd),
        .we_i(fwe), .waddr_i(fwa), .wdata_i(fwd));

    // Verdict and end of run
    task automatic wrap_up;
        if (error_cnt == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // One classic Wishbone cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] r);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        // Only the watchdog ends a wait for ack
        do
            @(posedge clk_i);
        while (ack !== 1'b1);
        r = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    // Run one op from given work, file value and flags, then check
    task automatic op(input logic [1:0] c, input logic d,
                      input logic [7:0] f, w, k, input logic [2:0] p,
                      input logic [6:0] a);
        logic [7:0] r;
        logic [2:0] ef;
        i_file.mem[a] = f;
        wb(1'b1, 8'h00, w, q);
        wb(1'b1, 8'h04, {5'h0, p}, q);
        @(posedge clk_i);
        opv <= 1'b1;
        opc <= c;
        dest <= d;
        fa <= a;
        lit <= k;
        @(posedge clk_i);
        opv <= 1'b0;
        @(posedge clk_i);
        `CHK("done", 1'b1, done)
        case (c)
            2'h0: r = f - w;
            2'h1: r = w ^ k;
            2'h2: r = {f[3:0], f[7:4]};
            default: r = w ^ f;
        endcase
        ef = p;
        if (c != 2'h2)
            ef[2] = (r == 8'h00);
        if (c == 2'h0)
            ef[1:0] = {w[3:0] <= f[3:0], w <= f};
        `CHK("flags", ef, flags)
        wb(1'b0, 8'h00, 8'h00, q);
        if (d && c != 2'h1)
        begin
            `CHK("file", r, i_file.mem[a])
            `CHK("work kept", w, q)
            `CHK("work pin kept", w, work)
        end
        else
        begin
            `CHK("work", r, q)
            `CHK("work pin", r, work)
        end
        // Last result register mirrors the op output
        wb(1'b0, 8'h08, 8'h00, q);
        `CHK("result", r, q)
    endtask

    // Clock
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // Watchdog
    initial
    begin
        repeat (3000) @(posedge clk_i);
        error_cnt++;
        wrap_up;
    end

    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h04, 8'h00, q);
        `CHK("status rst", 8'h00, q)
        wb(1'b1, 8'h0C, 8'h77, q);
        wb(1'b0, 8'h0C, 8'h00, q);
        `CHK("unmapped", 8'h00, q)
        // Write without the low byte lane must be ignored
        sel <= 4'hE;
        wb(1'b1, 8'h00, 8'h99, q);
        sel <= 4'hF;
        wb(1'b0, 8'h00, 8'h00, q);
        `CHK("sel lane", 8'h00, q)
        op(2'h0, 1'b0, 8'h35, 8'h35, 8'h00, 3'h0, 7'h08);
        op(2'h0, 1'b1, 8'h20, 8'h21, 8'h00, 3'h7, 7'h09);
        op(2'h0, 1'b0, 8'h21, 8'h13, 8'h00, 3'h0, 7'h0A);
        op(2'h1, 1'b1, 8'h00, 8'hA5, 8'hA5, 3'h3, 7'h0B);
        op(2'h2, 1'b1, 8'h3C, 8'h11, 8'h00, 3'h5, 7'h0C);
        op(2'h2, 1'b0, 8'h81, 8'h11, 8'h00, 3'h2, 7'h7F);
        op(2'h3, 1'b1, 8'h0F, 8'hF0, 8'h00, 3'h7, 7'h00);
        op(2'h3, 1'b0, 8'h5A, 8'h5A, 8'h00, 3'h3, 7'h0E);
        wrap_up;
    end
endmodule
`default_nettype wire
